// ---- core/backlight_defines.vh ----
// register offsets, field positions, reset values and timing counts of the backlight control
`ifndef BACKLIGHT_DEFINES_VH
`define BACKLIGHT_DEFINES_VH

// register offsets
`define REG_PWM_CTRL      8'h02
`define REG_BRT_LO        8'h04
`define REG_BRT_HI        8'h05
`define REG_SINK_EN       8'h08

// field positions
`define PWM_EN_BIT        0
`define PWM_POL_BIT       2
`define BL_ON_BIT         6
`define SINK_MSB          5

// reset values
`define PWM_CTRL_RST      8'h00
`define BRT_LO_RST        3'h7
`define BRT_HI_RST        8'h00
`define SINK_EN_RST       8'h00

// timing counts in clock cycles, and the ramp-down current step in code units
`define DETECT_CYCLES     8'h08
`define RAMP_DIV_CYCLES   8'h10
`define RAMP_STEP         11'h010

// power states
`define ST_STANDBY        2'h0
`define ST_STARTUP        2'h1
`define ST_RUN            2'h2
`define ST_RAMPDN         2'h3

`endif

// ---- core/i2c_reg_slave.v ----
// byte-wide i2c register slave with auto-incrementing pointer
`timescale 1ns/1ps
`default_nettype none

module i2c_reg_slave #(
   parameter [6:0] DEV_ADDR = 7'h11  // arbitrary value
) (
   // clock and reset
   input  wire       clk,
   input  wire       rst,
   // enable from power control
   input  wire       i2c_enable,
   // bus pins
   input  wire       scl_i,
   input  wire       sda_i,
   output wire       sda_o,
   output wire       sda_oe,
   // register port
   input  wire [7:0] rd_data,
   output wire [7:0] reg_addr,
   output wire       wr_stb,
   output wire [7:0] wr_data
);

   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_ADDR = 3'h1;
   localparam [2:0] S_RX   = 3'h2;
   localparam [2:0] S_ACK  = 3'h3;
   localparam [2:0] S_TX   = 3'h4;
   localparam [2:0] S_RACK = 3'h5;

   reg [2:0] state_ff;
   reg [3:0] cnt_ff;
   reg [7:0] sh_ff;
   reg [7:0] tx_ff;
   reg [7:0] ptr_ff;
   reg       rw_ff;
   reg       first_ff;
   reg       nack_ff;
   reg       oe_ff;
   reg       wr_stb_ff;
   reg [7:0] wr_data_ff;
   reg       scl_q_ff;
   reg       sda_q_ff;

   wire scl_rise = scl_i & ~scl_q_ff;
   wire scl_fall = ~scl_i & scl_q_ff;
   wire start_c  = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
   wire stop_c   = scl_i & scl_q_ff & ~sda_q_ff & sda_i;

   assign sda_o    = 1'b0;
   assign sda_oe   = oe_ff;
   assign reg_addr = ptr_ff;
   assign wr_stb   = wr_stb_ff;
   assign wr_data  = wr_data_ff;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff   <= S_IDLE;
         cnt_ff     <= 4'h0;
         sh_ff      <= 8'h00;
         tx_ff      <= 8'h00;
         ptr_ff     <= 8'h00;
         rw_ff      <= 1'b0;
         first_ff   <= 1'b0;
         nack_ff    <= 1'b0;
         oe_ff      <= 1'b0;
         wr_stb_ff  <= 1'b0;
         wr_data_ff <= 8'h00;
         scl_q_ff   <= 1'b1;
         sda_q_ff   <= 1'b1;
      end else begin
         scl_q_ff  <= scl_i;
         sda_q_ff  <= sda_i;
         wr_stb_ff <= 1'b0;
         // bus dead while disabled, no acknowledge
         if (!i2c_enable) begin
            state_ff <= S_IDLE;
            oe_ff    <= 1'b0;
         end else if (start_c) begin
            state_ff <= S_ADDR;
            cnt_ff   <= 4'h0;
            oe_ff    <= 1'b0;
         end else if (stop_c) begin
            state_ff <= S_IDLE;
            oe_ff    <= 1'b0;
         end else if (scl_rise) begin
            if (state_ff == S_ADDR || state_ff == S_RX) begin
               sh_ff  <= {sh_ff[6:0], sda_i};
               cnt_ff <= cnt_ff + 4'h1;
            end else if (state_ff == S_RACK) begin
               nack_ff <= sda_i;
            end
         end else if (scl_fall) begin
            case (state_ff)
               S_ADDR: begin
                  if (cnt_ff == 4'h8) begin
                     if (sh_ff[7:1] == DEV_ADDR) begin
                        oe_ff    <= 1'b1;
                        rw_ff    <= sh_ff[0];
                        first_ff <= ~sh_ff[0];
                        state_ff <= S_ACK;
                     end else begin
                        state_ff <= S_IDLE;
                     end
                  end
               end
               S_RX: begin
                  if (cnt_ff == 4'h8) begin
                     if (first_ff) begin
                        ptr_ff   <= sh_ff;
                        first_ff <= 1'b0;
                     end else begin
                        wr_stb_ff  <= 1'b1;
                        wr_data_ff <= sh_ff;
                     end
                     oe_ff    <= 1'b1;
                     state_ff <= S_ACK;
                  end
               end
               S_ACK: begin
                  cnt_ff <= 4'h0;
                  if (rw_ff) begin
                     tx_ff    <= {rd_data[6:0], 1'b0};
                     oe_ff    <= ~rd_data[7];
                     ptr_ff   <= ptr_ff + 8'h01;
                     state_ff <= S_TX;
                  end else begin
                     oe_ff    <= 1'b0;
                     state_ff <= S_RX;
                  end
               end
               S_TX: begin
                  if (cnt_ff == 4'h7) begin
                     oe_ff    <= 1'b0;
                     state_ff <= S_RACK;
                  end else begin
                     cnt_ff <= cnt_ff + 4'h1;
                     oe_ff  <= ~tx_ff[7];
                     tx_ff  <= {tx_ff[6:0], 1'b0};
                  end
               end
               S_RACK: begin
                  cnt_ff <= 4'h0;
                  if (nack_ff) begin
                     state_ff <= S_IDLE;
                  end else begin
                     tx_ff    <= {rd_data[6:0], 1'b0};
                     oe_ff    <= ~rd_data[7];
                     ptr_ff   <= ptr_ff + 8'h01;
                     state_ff <= S_TX;
                  end
               end
               default: state_ff <= S_IDLE;
            endcase
         end else if (wr_stb_ff) begin
            // auto-increment once the written byte has been handed over
            ptr_ff <= ptr_ff + 8'h01;
         end
      end
   end

endmodule // i2c_reg_slave

`default_nettype wire

// ---- core/backlight_enable_control.v ----
// power-state, sink-enable and brightness control of the led backlight
`timescale 1ns/1ps
`default_nettype none
`include "backlight_defines.vh"

// How it works
// - enable pin low puts device in shutdown and restores every register default.
// - in shutdown the i2c slave is held off and never acknowledges.
// - enable pin high gives standby with the i2c slave answering.
// - enable pin falling cuts sink current and puts i2c dead at once.
// - backlight off by register ramps current down, i2c stays alive.
// - sink-enable bits 5..0 switch each of six current sinks.
// - bit 6 of sink-enable turns backlight on, set after configuration.
// - sinks found grounded during startup are dropped automatically.
// - with pwm enabled and nonzero duty, brightness is scaled by duty.
// - standby keeps boost and all sinks off, register writes still work.
// - 11-bit code from two registers; low bits apply only on upper write.
module backlight_enable_control #(
   parameter [6:0] DEV_ADDR = 7'h11,  // arbitrary value
   parameter       NSINK    = 6
) (
   // clock and reset
   input  wire              clk,
   input  wire              rst,
   // power control pin
   input  wire              hw_enable_pin,
   // i2c pins
   input  wire              scl_i,
   input  wire              sda_i,
   output wire              sda_o,
   output wire              sda_oe,
   // pwm dimming input
   input  wire              pwm_in,
   // sink ground detectors
   input  wire [NSINK-1:0]  sink_grounded,
   // analog controls and power state
   output wire [10:0]       led_sink_current,
   output wire [NSINK-1:0]  sink_on,
   output wire              boost_on,
   output wire [1:0]        power_state
);

   // pin low resets everything without a clock
   wire rst_all = rst | ~hw_enable_pin;

   reg       en_s1_ff;
   reg       en_s2_ff;
   reg [7:0] pwm_ctrl_ff;
   reg [2:0] brt_lo_pend_ff;
   reg [2:0] brt_lo_ff;
   reg [7:0] brt_hi_ff;
   reg [7:0] sink_en_ff;
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [7:0] cnt_ff;
   reg [7:0] nxt_cnt;
   reg [10:0] cur_ff;
   reg [10:0] nxt_cur;
   reg [NSINK-1:0] drop_ff;
   reg [NSINK-1:0] sink_on_ff;
   reg       boost_ff;
   reg [10:0] win_ff;
   reg [11:0] hi_cnt_ff;
   reg [11:0] duty_ff;

   wire [7:0] reg_addr;
   wire       wr_stb;
   wire [7:0] wr_data;
   reg  [7:0] rd_data;

   // slave is reset with the device and gated by the synced pin
   i2c_reg_slave #(
      .DEV_ADDR (DEV_ADDR)
   ) u_slave (
      .clk        (clk),
      .rst        (rst_all),
      .i2c_enable (en_s2_ff),
      .scl_i      (scl_i),
      .sda_i      (sda_i),
      .sda_o      (sda_o),
      .sda_oe     (sda_oe),
      .rd_data    (rd_data),
      .reg_addr   (reg_addr),
      .wr_stb     (wr_stb),
      .wr_data    (wr_data)
   );

   // two-flop sync of the enable pin
   always @(posedge clk or posedge rst_all) begin
      if (rst_all) begin
         en_s1_ff <= 1'b0;
         en_s2_ff <= 1'b0;
      end else begin
         en_s1_ff <= 1'b1;
         en_s2_ff <= en_s1_ff;
      end
   end

   // register file, defaults under shutdown reset
   always @(posedge clk or posedge rst_all) begin
      if (rst_all) begin
         pwm_ctrl_ff    <= `PWM_CTRL_RST;
         brt_lo_pend_ff <= `BRT_LO_RST;
         brt_lo_ff      <= `BRT_LO_RST;
         brt_hi_ff      <= `BRT_HI_RST;
         sink_en_ff     <= `SINK_EN_RST;
      end else if (wr_stb) begin
         case (reg_addr)
            `REG_PWM_CTRL: pwm_ctrl_ff <= wr_data;
            // low bits wait in a holding register
            `REG_BRT_LO:   brt_lo_pend_ff <= wr_data[2:0];
            `REG_BRT_HI: begin
               brt_hi_ff <= wr_data;
               brt_lo_ff <= brt_lo_pend_ff;
            end
            // sink selects and backlight on bit; bit 7 reserved
            `REG_SINK_EN:  sink_en_ff <= {1'b0, wr_data[6:0]};
            default:       sink_en_ff <= sink_en_ff;
         endcase
      end
   end

   always @* begin
      case (reg_addr)
         `REG_PWM_CTRL: rd_data = pwm_ctrl_ff;
         `REG_BRT_LO:   rd_data = {5'h00, brt_lo_pend_ff};
         `REG_BRT_HI:   rd_data = brt_hi_ff;
         `REG_SINK_EN:  rd_data = sink_en_ff;
         default:       rd_data = 8'h00;
      endcase
   end

   // pwm duty over a fixed 2048-cycle window; coarse below ~25 kHz base resolution
   wire pwm_active = pwm_in ^ pwm_ctrl_ff[`PWM_POL_BIT];

   always @(posedge clk or posedge rst_all) begin
      if (rst_all) begin
         win_ff    <= 11'h000;
         hi_cnt_ff <= 12'h000;
         duty_ff   <= 12'h000;
      end else begin
         win_ff <= win_ff + 11'h001;
         if (win_ff == 11'h7ff) begin
            duty_ff   <= hi_cnt_ff + {11'h000, pwm_active};
            hi_cnt_ff <= 12'h000;
         end else begin
            hi_cnt_ff <= hi_cnt_ff + {11'h000, pwm_active};
         end
      end
   end

   wire [10:0]      code     = {brt_hi_ff, brt_lo_ff};
   wire             pwm_en   = pwm_ctrl_ff[`PWM_EN_BIT];
   wire [22:0]      product  = code * duty_ff;
   // scale by duty only when pwm is enabled
   wire [10:0]      target   = pwm_en ? product[21:11] : code;
   wire [NSINK-1:0] sink_sel = sink_en_ff[`SINK_MSB:0] & ~drop_ff;
   wire             bl_on    = sink_en_ff[`BL_ON_BIT];
   wire             want_on  = en_s2_ff & bl_on & (code != 11'h000) &
                               (sink_en_ff[`SINK_MSB:0] != 6'h00) &
                               (~pwm_en | (duty_ff != 12'h000));

   // per-sink drop of grounded outputs during startup
   genvar g;
   generate
      for (g = 0; g < NSINK; g = g + 1) begin : g_drop
         always @(posedge clk or posedge rst_all) begin
            if (rst_all)
               drop_ff[g] <= 1'b0;
            // kept while still wanted, so an all-grounded set does not retry forever
            else if (state_ff == `ST_STANDBY && !want_on)
               drop_ff[g] <= 1'b0;
            else if (state_ff == `ST_STARTUP && sink_en_ff[g] && sink_grounded[g])
               drop_ff[g] <= 1'b1;
         end
      end
   endgenerate

   always @* begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_cur   = cur_ff;
      case (state_ff)
         `ST_STANDBY: begin
            nxt_cur = 11'h000;
            nxt_cnt = 8'h00;
            // backlight starts only from the on bit
            if (want_on && sink_sel != {NSINK{1'b0}})
               nxt_state = `ST_STARTUP;
         end
         `ST_STARTUP: begin
            nxt_cnt = cnt_ff + 8'h01;
            if (!want_on) begin
               nxt_state = `ST_STANDBY;
            end else if (cnt_ff == `DETECT_CYCLES - 8'h01) begin
               nxt_cnt   = 8'h00;
               nxt_state = (sink_sel == {NSINK{1'b0}}) ? `ST_STANDBY : `ST_RUN;
            end
         end
         `ST_RUN: begin
            nxt_cur = target;
            // switching off by register ramps instead of cutting
            if (!want_on) begin
               nxt_cur   = cur_ff;
               nxt_state = `ST_RAMPDN;
            end
         end
         `ST_RAMPDN: begin
            nxt_cnt = cnt_ff + 8'h01;
            if (cnt_ff == `RAMP_DIV_CYCLES - 8'h01) begin
               nxt_cnt = 8'h00;
               if (cur_ff > `RAMP_STEP)
                  nxt_cur = cur_ff - `RAMP_STEP;
               else
                  nxt_cur = 11'h000;
            end
            if (cur_ff == 11'h000)
               nxt_state = `ST_STANDBY;
         end
         default: nxt_state = `ST_STANDBY;
      endcase
   end

   // shutdown reset zeroes current, sinks and boost at once
   always @(posedge clk or posedge rst_all) begin
      if (rst_all) begin
         state_ff   <= `ST_STANDBY;
         cnt_ff     <= 8'h00;
         cur_ff     <= 11'h000;
         sink_on_ff <= {NSINK{1'b0}};
         boost_ff   <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         cur_ff   <= nxt_cur;
         // sinks and boost only outside standby and startup
         if (nxt_state == `ST_RUN || nxt_state == `ST_RAMPDN) begin
            sink_on_ff <= sink_sel;
            boost_ff   <= 1'b1;
         end else begin
            sink_on_ff <= {NSINK{1'b0}};
            boost_ff   <= 1'b0;
         end
      end
   end

   assign led_sink_current = cur_ff;
   assign sink_on          = sink_on_ff;
   assign boost_on         = boost_ff;
   assign power_state      = state_ff;

endmodule // backlight_enable_control

`default_nettype wire

// ---- verification/i2c_host_model.sv ----
// i2c host model that drives the backlight control's register bus
`timescale 1ns/1ps
`default_nettype none

module i2c_host_model #(
   parameter [6:0] DEV   = 7'h11,  // arbitrary value
   parameter       PHASE = 4
) (
   // clock
   input  wire logic clk,
   // bus
   input  wire logic sda_oe,
   output var  logic scl,
   output wire logic sda
);
   logic drv_low;

   // pull-up: a released line reads high
   assign sda = ~(drv_low | sda_oe);

   initial begin
      scl     = 1'b1;
      drv_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic put_bit(input logic b);
      drv_low <= ~b;
      tick(PHASE);
      scl <= 1'b1;
      tick(PHASE);
      scl <= 1'b0;
      tick(1);
   endtask

   task automatic get_bit(output logic b);
      drv_low <= 1'b0;
      tick(PHASE);
      scl <= 1'b1;
      tick(PHASE / 2);
      b = sda;
      tick(PHASE - PHASE / 2);
      scl <= 1'b0;
      tick(1);
   endtask

   // also serves as repeated start
   task automatic start();
      drv_low <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(PHASE);
      drv_low <= 1'b1;
      tick(PHASE);
      scl <= 1'b0;
      tick(1);
   endtask

   task automatic stop();
      drv_low <= 1'b1;
      tick(PHASE);
      scl <= 1'b1;
      tick(PHASE);
      drv_low <= 1'b0;
      tick(PHASE);
   endtask

   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(s);
      ack = ~s;
   endtask

   task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                            input logic [7:0] d, output logic [2:0] acks);
      start();
      put_byte({dev, 1'b0}, acks[2]);
      put_byte(ptr, acks[1]);
      put_byte(d, acks[0]);
      stop();
   endtask

   task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
      logic a;
      start();
      put_byte({DEV, 1'b0}, a);
      put_byte(ptr, a);
      start();
      put_byte({DEV, 1'b1}, a);
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      // nack ends the read
      put_bit(1'b1);
      stop();
   endtask
endmodule // i2c_host_model

`default_nettype wire

// ---- verification/backlight_enable_props.sv ----
// port assertions of the backlight enable control
`timescale 1ns/1ps
`default_nettype none

module backlight_enable_props #(
   parameter NSINK = 6
) (
   input wire logic             clk,
   input wire logic             rst,
   input wire logic             hw_enable_pin,
   input wire logic             sda_oe,
   input wire logic [NSINK-1:0] sink_grounded,
   input wire logic [10:0]      led_sink_current,
   input wire logic [NSINK-1:0] sink_on,
   input wire logic             boost_on,
   input wire logic [1:0]       power_state
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_shutdown_quiet;
      !hw_enable_pin |-> led_sink_current == 11'h000 && sink_on == '0 && !boost_on
         && power_state == 2'h0;
   endproperty
   a_shutdown_quiet: assert property (p_shutdown_quiet)
      else $error("outputs active while enable pin low");

   property p_bus_dead;
      !hw_enable_pin |-> !sda_oe ##1 !sda_oe ##1 !sda_oe;
   endproperty
   a_bus_dead: assert property (p_bus_dead)
      else $error("bus driven in shutdown or sync window");

   property p_standby_off;
      power_state == 2'h0 && $past(power_state) == 2'h0 |-> !boost_on && sink_on == '0
         && led_sink_current == 11'h000;
   endproperty
   a_standby_off: assert property (p_standby_off)
      else $error("boost or sinks on in standby");

   property p_run_lights;
      power_state == 2'h2 |-> boost_on && sink_on != '0;
   endproperty
   a_run_lights: assert property (p_run_lights)
      else $error("run without boost or sinks");

   property p_drop_grounded;
      power_state == 2'h2 |-> (sink_on & sink_grounded) == '0;
   endproperty
   a_drop_grounded: assert property (p_drop_grounded)
      else $error("grounded sink left on");

   property p_startup_len;
      disable iff (rst || !hw_enable_pin)
      $rose(power_state == 2'h1) |-> (power_state == 2'h1) [*8] ##1 power_state != 2'h1;
   endproperty
   a_startup_len: assert property (p_startup_len)
      else $error("startup detect length wrong");

   property p_ramp_step;
      power_state == 2'h3 && $past(power_state) == 2'h3 |->
         $past(led_sink_current) >= led_sink_current
         && $past(led_sink_current) - led_sink_current <= 11'h010;
   endproperty
   a_ramp_step: assert property (p_ramp_step)
      else $error("ramp-down step wrong");

   property p_enable_sync;
      $rose(hw_enable_pin) |-> (power_state == 2'h0 && !boost_on) [*3];
   endproperty
   a_enable_sync: assert property (p_enable_sync)
      else $error("acted on enable before sync");
endmodule // backlight_enable_props

bind backlight_enable_control backlight_enable_props #(.NSINK(NSINK)) u_backlight_enable_props (
   .clk              (clk),
   .rst              (rst),
   .hw_enable_pin    (hw_enable_pin),
   .sda_oe           (sda_oe),
   .sink_grounded    (sink_grounded),
   .led_sink_current (led_sink_current),
   .sink_on          (sink_on),
   .boost_on         (boost_on),
   .power_state      (power_state)
);

`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench of the backlight enable control
`timescale 1ns/1ps
`default_nettype none
`include "backlight_defines.vh"

module tb_top;
   typedef struct packed {
      logic [5:0] mask;
      logic [5:0] gnd;
      logic [5:0] sink;
      logic [1:0] st;
   } row_t;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        hw_enable_pin = 1'b0;
   logic        pwm_in = 1'b0;
   logic        pwm_run = 1'b0;
   logic [3:0]  pwm_cnt = 4'h0;
   logic [5:0]  sink_grounded = 6'h00;
   wire         scl;
   wire         sda;
   wire         sda_oe;
   wire         sda_o;
   wire  [10:0] cur;
   wire  [5:0]  sink_on;
   wire         boost_on;
   wire  [1:0]  st;
   int          n_fail = 0;
   int          checked = 0;
   logic [7:0]  rd;
   logic [2:0]  acks;
   row_t        rows [4];

   always #10 clk = ~clk;

   // quarter-duty pwm source
   always @(posedge clk) begin
      pwm_cnt <= pwm_cnt + 4'h1;
      pwm_in  <= pwm_run & (pwm_cnt[3:2] == 2'h0);
   end

   backlight_enable_control u_backlight_enable_control (
      .clk (clk), .rst (rst), .hw_enable_pin (hw_enable_pin),
      .scl_i (scl), .sda_i (sda), .sda_o (sda_o), .sda_oe (sda_oe), .pwm_in (pwm_in),
      .sink_grounded (sink_grounded), .led_sink_current (cur), .sink_on (sink_on),
      .boost_on (boost_on), .power_state (st)
   );

   i2c_host_model u_i2c_host_model (.clk (clk), .sda_oe (sda_oe), .scl (scl), .sda (sda));

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
      u_i2c_host_model.write_reg(7'h11, ptr, d, acks);
      check("acks", 16'(acks), 16'h0007);
   endtask

   task automatic rdchk(input logic [7:0] ptr, input logic [7:0] exp);
      u_i2c_host_model.read_reg(ptr, rd);
      check("read", 16'(rd), 16'(exp));
   endtask

   task automatic end_sim();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      end_sim();
   end

   initial begin
      rows[0] = '{6'h01, 6'h00, 6'h01, `ST_RUN};
      rows[1] = '{6'h3f, 6'h00, 6'h3f, `ST_RUN};
      rows[2] = '{6'h3f, 6'h05, 6'h3a, `ST_RUN};
      rows[3] = '{6'h06, 6'h06, 6'h00, `ST_STANDBY};
      tick(20);
      check("reset current", 16'(cur), 16'h0000);
      check("reset outputs", 16'({sink_on, boost_on, st, sda_oe}), 16'h0000);
      check("sda level", 16'(sda_o), 16'h0000);
      rst <= 1'b0;
      hw_enable_pin <= 1'b1;
      // host stays off the bus 150 us
      tick(7500);
      rdchk(`REG_SINK_EN, 8'h00);
      $display("reset test done");
      // brightness set before the backlight bit
      wr(`REG_BRT_HI, 8'h10);
      for (int i = 0; i < 4; i++) begin
         sink_grounded <= rows[i].gnd;
         wr(`REG_SINK_EN, {2'h1, rows[i].mask});
         tick(20);
         check("sinks", 16'(sink_on), 16'(rows[i].sink));
         check("state", 16'(st), 16'(rows[i].st));
         check("current", 16'(cur), rows[i].st == `ST_RUN ? 16'h0087 : 16'h0000);
         wr(`REG_SINK_EN, 8'h00);
         tick(200);
         check("off state", 16'(st), 16'(`ST_STANDBY));
         $display("row %0d done", i);
      end
      wr(`REG_SINK_EN, 8'h41);
      tick(20);
      wr(`REG_SINK_EN, 8'h01);
      check("ramp state", 16'(st), 16'(`ST_RAMPDN));
      tick(200);
      check("ramp end", 16'(cur), 16'h0000);
      rdchk(`REG_SINK_EN, 8'h01);
      $display("ramp test done");
      wr(`REG_SINK_EN, 8'h41);
      tick(20);
      wr(`REG_BRT_LO, 8'h00);
      tick(4);
      check("pending low bits", 16'(cur), 16'h0087);
      rdchk(`REG_BRT_LO, 8'h00);
      wr(`REG_BRT_HI, 8'h10);
      tick(4);
      check("applied low bits", 16'(cur), 16'h0080);
      $display("brightness test done");
      // three duty windows per setting
      pwm_run <= 1'b1;
      wr(`REG_PWM_CTRL, 8'h01);
      tick(6200);
      check("pwm active high", 16'(cur), 16'h0020);
      wr(`REG_PWM_CTRL, 8'h05);
      tick(6200);
      check("pwm active low", 16'(cur), 16'h0060);
      pwm_run <= 1'b0;
      wr(`REG_PWM_CTRL, 8'h01);
      tick(6200);
      check("pwm zero duty", 16'(st), 16'(`ST_STANDBY));
      $display("pwm test done");
      wr(`REG_PWM_CTRL, 8'h04);
      tick(20);
      check("run again", 16'(st), 16'(`ST_RUN));
      hw_enable_pin <= 1'b0;
      #1;
      check("cut", 16'({cur, boost_on}), 16'h0000);
      u_i2c_host_model.write_reg(7'h11, `REG_BRT_HI, 8'h33, acks);
      check("dead bus", 16'(acks), 16'h0000);
      hw_enable_pin <= 1'b1;
      tick(7500);
      rdchk(`REG_PWM_CTRL, 8'h00);
      rdchk(`REG_BRT_LO, 8'h07);
      rdchk(`REG_BRT_HI, 8'h00);
      rdchk(`REG_SINK_EN, 8'h00);
      rdchk(8'h30, 8'h00);
      u_i2c_host_model.write_reg(7'h22, `REG_SINK_EN, 8'h41, acks);
      check("foreign address", 16'(acks), 16'h0000);
      check("still idle", 16'(st), 16'(`ST_STANDBY));
      $display("shutdown test done");
      end_sim();
   end
endmodule // tb_top

`default_nettype wire
